// [fault_manager_auto_restart.sv]
`include "fault_manager_map.svh"
// Overview of operation
// [RULE1] any fault stops the drive; each fault is class 1 or class 2
// [RULE2] class 1 fault with nonzero tries loads the restart delay timer
// [RULE3] when the delay timer reaches zero an automatic reset is tried
// [RULE4] automatic reset clears and restarts only if the cause is gone
// [RULE5] class 2 fault stays latched against every clear while its cause persists
// [RULE6] while a fault is active the code and indicator flash
// [RULE7] escape acknowledges and blanks the display without clearing the fault
// [RULE8] the latest fault code is kept for reading after acknowledge
// [RULE9] stop key clears a clearable fault when stop behaviour is 0 to 3
// [RULE10] fault clear command of 1 or 2 clears a clearable fault
// [RULE11] toggling a digital input set to function 7 clears a clearable fault
// [RULE12] nonzero tries and nonzero delay clear class 1 and restart
// [RULE13] nonzero tries and zero delay clear voltage and overtemp faults, no restart
// [RULE14] class 2 faults are never reset automatically
// [RULE15] after a successful auto reset with restart the block issues a start
// [RULE16] an open auxiliary interlock raises code 2, class 1
// [RULE17] each attempt uses one try; when none remain a manual clear is needed
module fault_manager_auto_restart
    import fault_manager_pkg::*;
#(
    parameter int TRY_W = 4,
    parameter int DELAY_W = 10,
    parameter int TICK_CYCLES = `FM_TICK_CYCLES,
    parameter int FLASH_CYCLES = `FM_FLASH_CYCLES
) (
    input wire logic clk_in, // 200 MHz system clock
    input wire logic rst_n_in, // async reset, active low
    input wire logic fault_detect_in, // pulse: a fault is detected
    input wire logic [`FM_CODE_W-1:0] fault_code_in, // code of the detected fault
    input wire logic fault_class2_in, // detected fault is class 2
    input wire logic fault_cause_in, // causing condition still present
    input wire logic aux_interlock_open_in, // auxiliary interlock open (pin)
    input wire logic escape_key_in, // escape key pulse
    input wire logic stop_key_in, // stop key pulse
    input wire logic [3:0] stop_behaviour_select_in, // stop mode setting
    input wire logic [3:0] fault_clear_command_in, // fault clear setting
    input wire logic fault_clear_write_in, // pulse: fault clear setting written
    input wire logic [5:0] digital_input1_function_in, // input 1 function
    input wire logic [5:0] digital_input2_function_in, // input 2 function
    input wire logic digital_input1_in, // digital input 1 (pin)
    input wire logic digital_input2_in, // digital input 2 (pin)
    input wire logic [TRY_W-1:0] restart_try_count_in, // restart tries setting
    input wire logic [DELAY_W-1:0] restart_delay_time_in, // delay in 100 ms ticks
    output logic fault_active_out, // a fault is latched
    output logic drive_stop_out, // forces the drive to stop
    output logic auto_start_out, // one-cycle self start command
    output logic fault_class2_out, // latched fault is class 2
    output logic display_fault_out, // fault number shown, flashing phase
    output logic fault_led_out, // flashing fault indicator
    output logic [`FM_CODE_W-1:0] latest_fault_code_out, // most recent fault code
    output logic [TRY_W-1:0] tries_left_out // remaining restart tries
);
    localparam int TICK_W = $clog2(TICK_CYCLES + 1);
    localparam int FLASH_W = $clog2(FLASH_CYCLES + 1);

    fm_state_t state;
    logic [1:0] aux_sync;
    logic [1:0] din1_sync;
    logic [1:0] din2_sync;
    logic din1_prev;
    logic din2_prev;
    logic acked;
    logic cause_gone_code_ok;
    logic [TICK_W-1:0] tick_cnt;
    logic tick;
    logic [DELAY_W-1:0] delay_cnt;
    logic [FLASH_W-1:0] flash_cnt;
    logic flash_phase;
    logic aux_event;
    logic aux_seen;
    logic new_fault;
    logic new_class2;
    logic [`FM_CODE_W-1:0] new_code;
    logic manual_clear;
    logic clear_ok;
    logic voltage_type;

    // two-flop synchronisers for pin inputs
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            aux_sync <= 2'h0;
            din1_sync <= 2'h0;
            din2_sync <= 2'h0;
            din1_prev <= 1'b0;
            din2_prev <= 1'b0;
            aux_seen <= 1'b0;
        end else begin
            aux_sync <= {aux_sync[0], aux_interlock_open_in};
            din1_sync <= {din1_sync[0], digital_input1_in};
            din2_sync <= {din2_sync[0], digital_input2_in};
            din1_prev <= din1_sync[1];
            din2_prev <= din2_sync[1];
            aux_seen <= aux_sync[1];
        end
    end

    // [RULE16] interlock raises class 1
    assign aux_event = aux_sync[1] && !aux_seen;
    assign new_fault = fault_detect_in || aux_event;
    assign new_class2 = aux_event ? 1'b0 : fault_class2_in;
    assign new_code = aux_event ? `FM_CODE_AUX_INTERLOCK : fault_code_in;

    // [RULE9] stop key clear
    // [RULE10] clear command values
    // [RULE11] input toggle clear
    assign manual_clear = (stop_key_in && stop_behaviour_select_in <= `FM_STOP_CLEAR_MAX)
        || (fault_clear_write_in && (fault_clear_command_in == `FM_CLEAR_CMD_A
            || fault_clear_command_in == `FM_CLEAR_CMD_B))
        || (digital_input1_function_in == `FM_DIN_FUNC_CLEAR && din1_sync[1] != din1_prev)
        || (digital_input2_function_in == `FM_DIN_FUNC_CLEAR && din2_sync[1] != din2_prev);

    // [RULE5] clears refused while cause persists
    assign clear_ok = !fault_cause_in;
    assign cause_gone_code_ok = !fault_cause_in;

    assign voltage_type = latest_fault_code_out == `FM_CODE_OVERVOLT
        || latest_fault_code_out == `FM_CODE_UNDERVOLT
        || latest_fault_code_out == `FM_CODE_COOLING_OVERTEMP;

    // delay tick divider, runs only while waiting
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            tick_cnt <= '0;
            tick <= 1'b0;
        end else if (state != st_delay || tick_cnt == TICK_W'(TICK_CYCLES - 1)) begin
            tick_cnt <= '0;
            tick <= (state == st_delay);
        end else begin
            tick_cnt <= tick_cnt + 1'b1;
            tick <= 1'b0;
        end
    end

    // fault supervisor state machine
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state <= st_idle;
            fault_active_out <= 1'b0;
            drive_stop_out <= 1'b0;
            auto_start_out <= 1'b0;
            fault_class2_out <= 1'b0;
            latest_fault_code_out <= `FM_CODE_NONE;
            tries_left_out <= '0;
            delay_cnt <= '0;
        end else begin
            auto_start_out <= 1'b0;
            case (state)
                st_idle: begin
                    tries_left_out <= restart_try_count_in;
                    if (new_fault) begin
                        // [RULE1] fault stops drive
                        fault_active_out <= 1'b1;
                        drive_stop_out <= 1'b1;
                        fault_class2_out <= new_class2;
                        // [RULE8] keep latest code
                        latest_fault_code_out <= new_code;
                        // [RULE2] load delay timer
                        // [RULE14] class 2 skips restart
                        if (!new_class2 && restart_try_count_in != '0) begin
                            delay_cnt <= restart_delay_time_in;
                            state <= st_delay;
                        end else begin
                            state <= st_latched;
                        end
                    end
                end
                st_latched: begin
                    if (manual_clear && clear_ok) begin
                        fault_active_out <= 1'b0;
                        drive_stop_out <= 1'b0;
                        fault_class2_out <= 1'b0;
                        state <= st_idle;
                    end
                end
                st_delay: begin
                    if (manual_clear && clear_ok) begin
                        fault_active_out <= 1'b0;
                        drive_stop_out <= 1'b0;
                        state <= st_idle;
                    // [RULE3] timer reaches zero
                    end else if (delay_cnt == '0) begin
                        state <= st_attempt;
                    end else if (tick) begin
                        delay_cnt <= delay_cnt - 1'b1;
                    end
                end
                st_attempt: begin
                    // [RULE17] one try per attempt
                    tries_left_out <= tries_left_out - 1'b1;
                    // [RULE4] reset only if cause gone
                    // [RULE13] zero delay: voltage and overtemp faults only
                    if (cause_gone_code_ok
                        && (restart_delay_time_in != '0 || voltage_type)) begin
                        fault_active_out <= 1'b0;
                        state <= (restart_delay_time_in != '0) ? st_start : st_idle;
                        drive_stop_out <= (restart_delay_time_in == '0);
                    end else if (tries_left_out > TRY_W'(1)) begin
                        delay_cnt <= restart_delay_time_in;
                        state <= st_delay;
                    end else begin
                        state <= st_latched;
                    end
                end
                st_start: begin
                    // [RULE12] clear and restart
                    // [RULE15] self start command
                    auto_start_out <= 1'b1;
                    drive_stop_out <= 1'b0;
                    state <= st_idle;
                end
                default: state <= st_idle;
            endcase
        end
    end

    // flash timer for display and indicator
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            flash_cnt <= '0;
            flash_phase <= 1'b0;
        end else if (!fault_active_out) begin
            flash_cnt <= '0;
            flash_phase <= 1'b0;
        end else if (flash_cnt == FLASH_W'(FLASH_CYCLES - 1)) begin
            flash_cnt <= '0;
            flash_phase <= !flash_phase;
        end else begin
            flash_cnt <= flash_cnt + 1'b1;
        end
    end

    // acknowledge tracking
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            acked <= 1'b0;
        end else if (new_fault && state == st_idle) begin
            acked <= 1'b0;
        // [RULE7] escape blanks display only
        end else if (escape_key_in && fault_active_out) begin
            acked <= 1'b1;
        end
    end

    // [RULE6] flashing display and indicator
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            display_fault_out <= 1'b0;
            fault_led_out <= 1'b0;
        end else begin
            display_fault_out <= fault_active_out && !acked && !flash_phase;
            fault_led_out <= fault_active_out && !flash_phase;
        end
    end

    // [RULE1] active fault holds stop
    AST_FAULT_STOPS: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (state == st_latched || state == st_delay) |-> drive_stop_out)
        else $error("fault latched without stop");
    // [RULE14] class 2 never auto reset
    AST_CLASS2_NO_AUTO: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        fault_class2_out |-> state != st_delay && state != st_attempt)
        else $error("class 2 fault in auto restart");
    // [RULE5] cause present blocks clear
    AST_CAUSE_HOLDS: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (state == st_latched && fault_cause_in) |=> fault_active_out)
        else $error("fault cleared while cause present");
    // [RULE15] start follows attempt
    AST_START_AFTER: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        $rose(auto_start_out) |-> $past(state, 2) == st_attempt)
        else $error("start without auto reset");
    // [RULE2] delay loaded on class 1
    AST_DELAY_LOAD: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (state == st_idle && new_fault && !new_class2 && restart_try_count_in != '0)
        |=> state == st_delay && delay_cnt == $past(restart_delay_time_in))
        else $error("delay not loaded");
    // [RULE3] zero delay leads to attempt
    AST_ZERO_ATTEMPT: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (state == st_delay && delay_cnt == '0 && !manual_clear) |=> state == st_attempt)
        else $error("no attempt at zero");
    // [RULE7] escape keeps fault
    AST_ESC_KEEPS: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (escape_key_in && state == st_latched && !manual_clear) |=> fault_active_out)
        else $error("escape cleared fault");
    // [RULE17] attempt uses a try
    AST_TRY_USED: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        state == st_attempt |=> tries_left_out == $past(tries_left_out) - 1'b1)
        else $error("try not consumed");
endmodule

// [fault_manager_auto_restart_tb.sv]
module fault_manager_auto_restart_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import fault_manager_pkg::*;
    typedef struct packed {
        logic [1:0] how;
        logic [3:0] stop_sel;
        logic [3:0] cmd;
        logic [5:0] func;
        logic clears;
    } row_t;
    // clear method 0 stop, 1 clear write, 2 pin 1, 3 pin 2
    row_t rows [9] = '{'{2'd0, 4'h0, 4'h0, 6'h00, 1'b1}, '{2'd0, 4'h3, 4'h0, 6'h00, 1'b1},
        '{2'd0, 4'h4, 4'h0, 6'h00, 1'b0}, '{2'd1, 4'h4, 4'h1, 6'h00, 1'b1},
        '{2'd1, 4'h4, 4'h2, 6'h00, 1'b1}, '{2'd1, 4'h4, 4'h3, 6'h00, 1'b0},
        '{2'd2, 4'h4, 4'h0, 6'h07, 1'b1}, '{2'd3, 4'h4, 4'h0, 6'h07, 1'b1},
        '{2'd2, 4'h4, 4'h0, 6'h06, 1'b0}};
    logic clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic detect = 1'b0, cls2 = 1'b0, cause = 1'b0, aux = 1'b0, clr_wr = 1'b0;
    logic [7:0] code = 8'h00;
    logic [3:0] stop_sel = 4'h4, clr_cmd = 4'h0, tries = 4'h0;
    logic [5:0] func = 6'h00, func2 = 6'h00;
    logic [9:0] delay = 10'h000;
    logic stop_k, esc_k, din1, din2, active, stop, start, c2, disp, led;
    logic [7:0] latest;
    logic [3:0] left;
    int mismatches = 0, compares = 0, cycles = 0, hi, lo, t0;
    fault_manager_auto_restart #(.TICK_CYCLES(4), .FLASH_CYCLES(8)) i_fault_manager_auto_restart (
        .clk_in(clk_in), .rst_n_in(rst_n_in), .fault_detect_in(detect), .fault_code_in(code),
        .fault_class2_in(cls2), .fault_cause_in(cause), .aux_interlock_open_in(aux),
        .escape_key_in(esc_k), .stop_key_in(stop_k), .stop_behaviour_select_in(stop_sel),
        .fault_clear_command_in(clr_cmd), .fault_clear_write_in(clr_wr),
        .digital_input1_function_in(func), .digital_input2_function_in(func2),
        .digital_input1_in(din1), .digital_input2_in(din2), .restart_try_count_in(tries),
        .restart_delay_time_in(delay), .fault_active_out(active), .drive_stop_out(stop),
        .auto_start_out(start), .fault_class2_out(c2), .display_fault_out(disp),
        .fault_led_out(led), .latest_fault_code_out(latest), .tries_left_out(left));
    keypad_io_model i_keypad_io_model (.clk_in(clk_in), .auto_start_in(start),
        .stop_key_out(stop_k), .escape_key_out(esc_k), .din1_out(din1), .din2_out(din2));
    // 200 MHz clock
    initial begin
        forever #2.5 clk_in = ~clk_in;
    end
    // hang guard
    always @(posedge clk_in) begin
        cycles++;
        if (cycles == 30000) begin
            mismatches++;
            results();
        end
    end
    task automatic step(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // one-cycle detect pulse, outputs checked one cycle later
    task automatic raise(input logic [7:0] c, input logic k2);
        step(1);
        detect = 1'b1;
        code = c;
        cls2 = k2;
        step(1);
        detect = 1'b0;
        step(1);
    endtask
    task automatic clr(input logic [3:0] v);
        step(1);
        clr_cmd = v;
        clr_wr = 1'b1;
        step(1);
        clr_wr = 1'b0;
        step(6);
    endtask
    task automatic results();
        $display("mismatches %0d compares %0d", mismatches, compares);
        if (mismatches == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    initial begin
        step(2);
        check({active, stop, start, c2, disp, led, 2'b00}, 8'h00);
        step(8);
        rst_n_in = 1'b1;
        check(latest, 8'h00);
        // manual clear methods, one row each
        foreach (rows[i]) begin
            stop_sel = rows[i].stop_sel;
            func = rows[i].func;
            func2 = rows[i].func;
            raise(8'h07, 1'b0);
            check({active, stop, c2}, 8'h06);
            case (rows[i].how)
                2'd0: i_keypad_io_model.key(0);
                2'd1: clr(rows[i].cmd);
                default: i_keypad_io_model.pin(int'(rows[i].how) - 2);
            endcase
            step(6);
            check({7'h00, active}, {7'h00, ~rows[i].clears});
            clr(4'h1);
            check({7'h00, active}, 8'h00);
        end
        // input 2 ignores the clear function chosen for input 1
        func = 6'h07;
        func2 = 6'h00;
        raise(8'h07, 1'b0);
        i_keypad_io_model.pin(1);
        step(6);
        check({7'h00, active}, 8'h01);
        clr(4'h1);
        // flashing display, then escape blanks it but keeps the fault
        raise(8'h08, 1'b0);
        {hi, lo} = '0;
        repeat (40) begin
            step(1);
            hi += (disp === 1'b1 && led === 1'b1);
            lo += (disp === 1'b0 && led === 1'b0);
        end
        check({6'h00, hi > 0, lo > 0}, 8'h03);
        i_keypad_io_model.key(1);
        step(20);
        check({disp, active, 6'h00}, 8'h40);
        check(latest, 8'h08);
        clr(4'h2);
        // class 2 with cause present refuses every clear
        cause = 1'b1;
        stop_sel = 4'h0;
        func = 6'h07;
        raise(8'h0c, 1'b1);
        i_keypad_io_model.key(0);
        clr(4'h1);
        i_keypad_io_model.pin(0);
        step(6);
        check({active, c2}, 8'h03);
        cause = 1'b0;
        clr(4'h1);
        check({active, c2}, 8'h00);
        // class 2 is never reset by the restart sequencer
        tries = 4'h3;
        delay = 10'h001;
        raise(8'h0d, 1'b1);
        t0 = i_keypad_io_model.starts;
        step(60);
        check({active, 7'h00}, 8'h80);
        clr(4'h1);
        // class 1 restart: delay elapses, fault clears, self start follows
        tries = 4'h2;
        delay = 10'h002;
        raise(8'h06, 1'b0);
        hi = 0;
        while (i_keypad_io_model.starts == t0 && hi < 100) begin
            step(1);
            hi++;
        end
        check({6'h00, hi >= 6, hi < 100}, 8'h03);
        step(1);
        check({active, stop, 6'h00}, 8'h00);
        // one try, cause stays: attempt fails, fault stays latched
        tries = 4'h1;
        delay = 10'h001;
        cause = 1'b1;
        t0 = i_keypad_io_model.starts;
        raise(8'h06, 1'b0);
        step(60);
        cause = 1'b0;
        step(60);
        check({active, 7'h00}, 8'h80);
        check(i_keypad_io_model.starts[7:0], t0[7:0]);
        check({4'h0, left}, 8'h00);
        clr(4'h1);
        // zero delay: voltage and overtemp faults clear without a start
        delay = 10'h000;
        for (int j = 0; j < 3; j++) begin
            raise(j == 0 ? 8'h04 : (j == 1 ? 8'h05 : 8'h08), 1'b0);
            step(10);
            check({active, stop, 6'h00}, 8'h40);
        end
        check(i_keypad_io_model.starts[7:0], t0[7:0]);
        // open interlock raises code 2 as class 1
        tries = 4'h0;
        aux = 1'b1;
        step(6);
        check({latest[6:0], active}, {8'h02 << 1} | {7'h00, 1'b1});
        check({7'h00, c2}, 8'h00);
        aux = 1'b0;
        clr(4'h1);
        results();
    end
endmodule

// [fault_manager_map.svh]
`ifndef FAULT_MANAGER_MAP_SVH
`define FAULT_MANAGER_MAP_SVH

// fault code width and codes
`define FM_CODE_W 8
`define FM_CODE_AUX_INTERLOCK 8'h02
`define FM_CODE_UNDERVOLT 8'h04
`define FM_CODE_OVERVOLT 8'h05
`define FM_CODE_COOLING_OVERTEMP 8'h08
`define FM_CODE_NONE 8'h00

// stop behaviour values that allow a stop-key clear
`define FM_STOP_CLEAR_MAX 4'h3

// fault clear command values
`define FM_CLEAR_CMD_A 4'h1
`define FM_CLEAR_CMD_B 4'h2

// digital input function that clears a fault
`define FM_DIN_FUNC_CLEAR 6'h07

// restart delay tick: 100 ms at 200 MHz
`define FM_TICK_NS 100000000
`define FM_CLK_NS 5
`define FM_TICK_CYCLES (`FM_TICK_NS / `FM_CLK_NS)

// display flash half period: 250 ms
`define FM_FLASH_NS 250000000
`define FM_FLASH_CYCLES (`FM_FLASH_NS / `FM_CLK_NS)

`endif

// [fault_manager_pkg.sv]
package fault_manager_pkg;
    // fault class
    typedef enum logic {
        class_auto_reset,
        class_non_reset
    } fault_class_t;

    // supervisor state
    typedef enum logic [2:0] {
        st_idle,
        st_latched,
        st_delay,
        st_attempt,
        st_start
    } fm_state_t;
endpackage

// [keypad_io_model.sv]
module keypad_io_model (
    input wire logic clk_in, // system clock
    input wire logic auto_start_in, // self start from the block
    output logic stop_key_out, // stop key pulse
    output logic escape_key_out, // escape key pulse
    output logic din1_out, // digital input 1 pin
    output logic din2_out // digital input 2 pin
);
    timeunit 1ns;
    timeprecision 1ps;
    int starts = 0;
    // keys idle low, pins start low
    initial begin
        stop_key_out = 1'b0;
        escape_key_out = 1'b0;
        din1_out = 1'b0;
        din2_out = 1'b0;
    end
    // run controller side: count self start pulses
    always @(posedge clk_in) begin
        if (auto_start_in === 1'b1) begin
            starts++;
        end
    end
    // one-cycle key press, 0 is stop and 1 is escape
    task automatic key(input int which);
        @(posedge clk_in);
        #1;
        if (which == 0) begin
            stop_key_out = 1'b1;
        end else begin
            escape_key_out = 1'b1;
        end
        @(posedge clk_in);
        #1;
        stop_key_out = 1'b0;
        escape_key_out = 1'b0;
    endtask
    // flip a digital input pin and hold the new level
    task automatic pin(input int which);
        @(posedge clk_in);
        #1;
        if (which == 0) begin
            din1_out = ~din1_out;
        end else begin
            din2_out = ~din2_out;
        end
    endtask
endmodule
